/* File: rtl/auto_wake_unit.sv */
// Auto wake-up from halt with AHB-Lite register slave
// Assumes halt_active is synchronous to hclk; wake_osc_in is asynchronous
//
// Functional notes
// - Wake flag set by hardware, cleared on read
// - Writes to the wake flag are ignored
// - Measure enable runs oscillator, routes to capture
// - Wake enable gates automatic wake from halt
// - Prescaler code equals dividing factor one-255
// - Delay is 64 x factor periods plus start-up
// - Prescaler zero is forbidden; previous value kept
// - Control/status resets zero; bits 7:3 read zero
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module auto_wake_unit
#(
	parameter int STARTUP_CYCLES = wake_pkg::STARTUP_CYCLES
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [wake_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Power management
	input wire logic halt_active,
	output logic wake_request,
	// Wake RC oscillator
	input wire logic wake_osc_in,
	output logic wake_osc_enable,
	output logic capture_input,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0] prescaler;
		logic wake_flag;
		logic measure_enable;
		logic wake_enable;
		logic [7:0] irq_status;
		logic [7:0] irq_mask;
		logic wr_pending;
		logic [wake_pkg::ADDR_W-1:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		wake_pkg::wake_state_e fsm;
		logic [wake_pkg::COUNT_W-1:0] count;
		logic halt_d;
		logic osc_d;
		logic osc_en;
		logic capture;
		logic wake_req;
		logic irq;
	} state_s;

	localparam state_s RESET_STATE = '{
		prescaler: wake_pkg::PRESCALER_RESET,
		ready: 1'b1,
		fsm: wake_pkg::ST_IDLE,
		default: '0
	};
	localparam logic [wake_pkg::COUNT_W-1:0] STARTUP_LAST =
		wake_pkg::COUNT_W'(STARTUP_CYCLES - 1);

	state_s s;
	state_s next_s;
	logic osc_sync;
	logic addr_valid;
	logic rd_csr;
	logic rc_rise;
	logic halt_rise;
	logic wake_evt;
	logic [wake_pkg::COUNT_W-1:0] count_last;

	// ------------------------------------------------------------
	// Oscillator crossing
	// ------------------------------------------------------------
	// Free-running RC clock is sampled, never used as a clock
	level_sync #(.W(1)) u_osc_sync
	(
		.clk(hclk),
		.rst_n(hresetn),
		.d(wake_osc_in),
		.q(osc_sync)
	);

	// Read mux; reserved bits and unmapped addresses read zero
	function automatic logic [31:0] read_mux(
		input logic [wake_pkg::ADDR_W-1:0] addr,
		input state_s v
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (addr)
			wake_pkg::ADDR_PRESCALER: r[7:0] = v.prescaler;
			wake_pkg::ADDR_CTRL_STATUS:
			begin
				r[wake_pkg::CSR_FLAG_BIT] = v.wake_flag;
				r[wake_pkg::CSR_MEASURE_BIT] = v.measure_enable;
				r[wake_pkg::CSR_ENABLE_BIT] = v.wake_enable;
			end
			wake_pkg::ADDR_IRQ_STATUS: r[7:0] = v.irq_status;
			wake_pkg::ADDR_IRQ_MASK: r[7:0] = v.irq_mask;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Decode of the current address phase
	assign addr_valid = hsel && htrans[1] && hready;
	assign rd_csr = addr_valid && !hwrite && (haddr == wake_pkg::ADDR_CTRL_STATUS);
	assign rc_rise = osc_sync && !s.osc_d;
	assign halt_rise = halt_active && !s.halt_d;
	// Terminal count is 64 x factor - 1 RC edges
	assign count_last = {s.prescaler, 6'h00} - wake_pkg::COUNT_W'(1);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Bus writes first, then reads, then hardware events so a set wins
	always_comb
	begin
		next_s = s;
		wake_evt = 1'b0;
		next_s.ready = 1'b1;
		next_s.resp = 1'b0;
		next_s.halt_d = halt_active;
		next_s.osc_d = osc_sync;
		next_s.wake_req = 1'b0;

		// Write data phase; only whole words are expected
		if (s.wr_pending)
		begin
			case (s.wr_addr)
				wake_pkg::ADDR_PRESCALER:
				begin
					// Forbidden zero leaves the old factor
					if (hwdata[7:0] != wake_pkg::PRESCALER_FORBIDDEN)
						next_s.prescaler = hwdata[7:0];
				end
				wake_pkg::ADDR_CTRL_STATUS:
				begin
					// Flag bit is not writable
					next_s.measure_enable = hwdata[wake_pkg::CSR_MEASURE_BIT];
					next_s.wake_enable = hwdata[wake_pkg::CSR_ENABLE_BIT];
				end
				wake_pkg::ADDR_IRQ_STATUS: next_s.irq_status = s.irq_status & ~hwdata[7:0];
				wake_pkg::ADDR_IRQ_MASK: next_s.irq_mask = hwdata[7:0];
				default: next_s.wr_addr = s.wr_addr;
			endcase
		end
		next_s.wr_pending = addr_valid && hwrite;
		next_s.wr_addr = haddr;

		// Read data taken from post-write values, ready in the data phase
		if (addr_valid && !hwrite)
			next_s.rdata = read_mux(haddr, next_s);
		if (rd_csr)
			next_s.wake_flag = 1'b0;

		// Wake sequencer
		case (s.fsm)
			wake_pkg::ST_IDLE:
			begin
				if (halt_rise && s.wake_enable)
				begin
					next_s.fsm = wake_pkg::ST_START;
					next_s.count = '0;
				end
			end
			wake_pkg::ST_START:
			begin
				// Oscillator edges are unreliable until start-up ends
				if (!halt_active)
					next_s.fsm = wake_pkg::ST_IDLE;
				else if (s.count == STARTUP_LAST)
				begin
					next_s.fsm = wake_pkg::ST_COUNT;
					next_s.count = '0;
				end
				else
					next_s.count = s.count + wake_pkg::COUNT_W'(1);
			end
			wake_pkg::ST_COUNT:
			begin
				if (!halt_active)
					next_s.fsm = wake_pkg::ST_IDLE;
				else if (rc_rise)
				begin
					if (s.count == count_last)
					begin
						wake_evt = 1'b1;
						next_s.fsm = wake_pkg::ST_DONE;
					end
					else
						next_s.count = s.count + wake_pkg::COUNT_W'(1);
				end
			end
			wake_pkg::ST_DONE:
			begin
				// Wait for the core to leave halt before re-arming
				if (!halt_active)
					next_s.fsm = wake_pkg::ST_IDLE;
			end
			default: next_s.fsm = wake_pkg::ST_IDLE;
		endcase

		// Hardware set beats a read clear in the same cycle
		if (wake_evt)
		begin
			next_s.wake_flag = 1'b1;
			next_s.irq_status[wake_pkg::IRQ_WAKE_BIT] = 1'b1;
			next_s.wake_req = 1'b1;
		end

		// Oscillator runs while measuring or while a delay is in progress
		next_s.osc_en = next_s.measure_enable ||
			(next_s.fsm == wake_pkg::ST_START) || (next_s.fsm == wake_pkg::ST_COUNT);
		next_s.capture = next_s.measure_enable && osc_sync;
		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= RESET_STATE;
		else
			s <= next_s;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// All outputs come straight from the state register
	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = s.resp;
	assign wake_request = s.wake_req;
	assign wake_osc_enable = s.osc_en;
	assign capture_input = s.capture;
	assign irq = s.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence seq_halt_entry;
		halt_rise && s.wake_enable && (s.fsm == wake_pkg::ST_IDLE);
	endsequence

	sequence seq_osc_running;
		(s.fsm == wake_pkg::ST_START) && s.osc_en;
	endsequence

	chk_flag_set_wake: assert property (s.wake_req |-> s.wake_flag)
		else $error("wake flag not set with wake request");
	chk_flag_fall_read: assert property ($fell(s.wake_flag) |-> $past(rd_csr))
		else $error("wake flag cleared without a status read");
	chk_flag_rise_hw: assert property ($rose(s.wake_flag) |-> $past(wake_evt))
		else $error("wake flag rose without a wake event");
	chk_measure_osc_on: assert property (s.measure_enable |-> s.osc_en)
		else $error("oscillator off while measuring");
	chk_capture_gated: assert property (!s.measure_enable |-> !s.capture)
		else $error("capture path active with measurement off");
	chk_no_auto_wake: assert property
		((s.fsm == wake_pkg::ST_IDLE) && !s.wake_enable |=> s.fsm == wake_pkg::ST_IDLE)
		else $error("wake sequence started while disabled");
	chk_prescaler_nonzero: assert property (s.prescaler != 8'h00)
		else $error("prescaler holds the forbidden code");
	chk_wake_at_count: assert property
		(wake_evt |-> rc_rise && (s.count == count_last) && (s.fsm == wake_pkg::ST_COUNT))
		else $error("wake issued at wrong count");
	chk_reserved_zero: assert property (rd_csr |=> s.rdata[31:3] == 29'h0000_0000)
		else $error("reserved status bits read nonzero");
	chk_halt_start: assert property (seq_halt_entry |=> seq_osc_running)
		else $error("halt entry did not start the oscillator");
	chk_startup_done: assert property
		((s.fsm == wake_pkg::ST_START) && (s.count == STARTUP_LAST) && halt_active
		|=> (s.fsm == wake_pkg::ST_COUNT) && (s.count == '0))
		else $error("start-up wait did not end on time");
	chk_wake_stops: assert property (wake_evt |=> (s.fsm != wake_pkg::ST_COUNT) ##1 !s.wake_req)
		else $error("count kept running after wake");

endmodule

/* File: rtl/level_sync.sv */
// Two-flop synchroniser for asynchronous levels
// Assumes the input may change at any time relative to clk
`timescale 1ns/1ps
module level_sync
#(
	parameter int W = 1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed
	{
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_s;

	sync_s s;
	sync_s next_s;

	// First stage is read only by the second stage
	always_comb
	begin
		next_s.meta = d;
		next_s.stable = s.meta;
	end

	// Register stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign q = s.stable;

endmodule

/* File: rtl/wake_pkg.sv */
// Package: shared constants and types for the auto wake-up unit
// Assumes a 25 MHz system clock and a word-aligned AHB-Lite register map
package wake_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_PRESCALER = 12'h0049;
	localparam logic [ADDR_W-1:0] IDX_CTRL_STATUS = 12'h004a;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h004b;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h004c;
	localparam logic [ADDR_W-1:0] ADDR_PRESCALER = {IDX_PRESCALER[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[ADDR_W-3:0], 2'b00};

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int CSR_ENABLE_BIT = 0;
	localparam int CSR_MEASURE_BIT = 1;
	localparam int CSR_FLAG_BIT = 2;
	localparam int IRQ_WAKE_BIT = 0;
	localparam logic [7:0] PRESCALER_RESET = 8'hff;
	localparam logic [7:0] PRESCALER_FORBIDDEN = 8'h00;
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int RC_CYCLES_PER_STEP_LOG2 = 6;
	localparam int COUNT_W = 14;
	localparam int CLK_PERIOD_NS = 40;
	localparam int WAKE_OSC_STARTUP_TIME_NS = 20000;
	localparam int STARTUP_CYCLES = (WAKE_OSC_STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Wake sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_COUNT = 2'b10,
		ST_DONE = 2'b11
	} wake_state_e;

endpackage

/* File: testbench/auto_wake_unit_tb_top.sv */
// Self-checking bench for the auto wake-up unit: registers, wake delay, measurement
// Assumes the design answers with zero wait states and a shortened start-up count
`timescale 1ns/1ps
module auto_wake_unit_tb_top;

	// ------------------------------------------------------------
	// Signals and settings
	// ------------------------------------------------------------
	localparam int SU = 4;
	localparam int LIMIT = 20000;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [wake_pkg::ADDR_W-1:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic halt_active = 1'b0;
	logic wake_request;
	logic wake_osc_in = 1'b0;
	logic wake_osc_enable;
	logic capture_input;
	logic irq;
	logic [2:0] osc_cnt = 3'b000;
	logic [2:0] osc_hist = 3'h0;
	logic [31:0] rd;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;

	// Clock, 40 ns period
	always #20 hclk = ~hclk;

	// RC oscillator stands still while disabled; period of eight clocks
	always @(posedge hclk)
	begin
		osc_cnt <= wake_osc_enable ? osc_cnt + 3'd1 : 3'd0;
		wake_osc_in <= wake_osc_enable & osc_cnt[2];
		// Pin history; capture must follow the pin three clocks late
		osc_hist <= {osc_hist[1:0], wake_osc_in};
	end

	// Hang guard
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			errors++;
			print_verdict();
		end
	end

	auto_wake_unit #(.STARTUP_CYCLES(SU)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.halt_active(halt_active), .wake_request(wake_request),
		.wake_osc_in(wake_osc_in), .wake_osc_enable(wake_osc_enable),
		.capture_input(capture_input), .irq(irq));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single AHB transfer; hready sampled before the edge's updates land
	task automatic ahb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
		check({31'd0, hresp}, 32'h0000_0000);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(a, 1'b1, d, q);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb_xfer(a, 1'b0, 32'h0000_0000, q);
		check(q, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, an unmapped place, and the forbidden prescaler code
	task automatic t_regs();
		rd_chk(wake_pkg::ADDR_PRESCALER, 32'h0000_00ff);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		rd_chk(12'h200, 32'h0000_0000);
		wr(wake_pkg::ADDR_PRESCALER, 32'h0000_0002);
		rd_chk(wake_pkg::ADDR_PRESCALER, 32'h0000_0002);
		wr(wake_pkg::ADDR_PRESCALER, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_PRESCALER, 32'h0000_0002);
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_00fc);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0000);
	endtask

	// Full wake delay for one prescaler code, then flag and interrupt handling
	task automatic t_wake(input logic [7:0] p);
		int n;
		int lo;
		lo = 512 * p;
		wr(wake_pkg::ADDR_PRESCALER, {24'h00_0000, p});
		wr(wake_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0001);
		@(posedge hclk);
		halt_active <= 1'b1;
		n = 0;
		while (wake_request !== 1'b1 && n < 4000)
		begin
			@(posedge hclk);
			n++;
		end
		check({31'd0, n >= lo && n <= lo + SU + 40}, 32'h0000_0001);
		idle(2);
		check({31'd0, irq}, 32'h0000_0001);
		check({31'd0, wake_osc_enable}, 32'h0000_0000);
		// A write with the flag bit low must leave the flag standing
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0001);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0005);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0001);
		wr(wake_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		idle(2);
		check({31'd0, irq}, 32'h0000_0000);
		wr(wake_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		idle(2);
		check({31'd0, irq}, 32'h0000_0001);
		wr(wake_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
		idle(2);
		check({31'd0, irq}, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
		halt_active <= 1'b0;
		idle(2);
	endtask

	// Halt with wake disabled: no wake within well over the delay
	task automatic t_no_wake();
		int seen;
		seen = 0;
		wr(wake_pkg::ADDR_PRESCALER, 32'h0000_0001);
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0000);
		@(posedge hclk);
		halt_active <= 1'b1;
		repeat (800)
		begin
			@(posedge hclk);
			if (wake_request === 1'b1)
				seen++;
		end
		check(seen, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0000);
		halt_active <= 1'b0;
	endtask

	// Measurement path runs the oscillator and passes it through, and stops when off
	task automatic t_measure();
		int hi;
		int lo;
		int bad;
		hi = 0;
		lo = 0;
		bad = 0;
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0002);
		idle(4);
		check({31'd0, wake_osc_enable}, 32'h0000_0001);
		repeat (40)
		begin
			@(posedge hclk);
			if (capture_input === 1'b1)
				hi++;
			if (capture_input === 1'b0)
				lo++;
			if (capture_input !== osc_hist[2])
				bad++;
		end
		check({31'd0, hi > 10 && lo > 10}, 32'h0000_0001);
		check(bad, 32'h0000_0000);
		rd_chk(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0002);
		wr(wake_pkg::ADDR_CTRL_STATUS, 32'h0000_0000);
		idle(8);
		hi = 0;
		repeat (24)
		begin
			@(posedge hclk);
			if (capture_input !== 1'b0 || wake_osc_enable !== 1'b0)
				hi++;
		end
		check(hi, 32'h0000_0000);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		idle(10);
		hresetn <= 1'b1;
		idle(2);
		t_regs();
		t_wake(8'h01);
		t_wake(8'h02);
		t_no_wake();
		t_measure();
		print_verdict();
	end

endmodule
